// [design/stpc_translator_top.sv]
// Stepper phase translator with dual chopper and AHB-Lite status and control
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "stpc_regs.svh"
module stpc_translator_top
  import stpc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        step_clock,
  input  wire logic        rotation_direction,
  input  wire logic        half_step_sel,
  input  wire logic        chip_enable,
  input  wire logic        translator_reset_n,
  input  wire logic        chop_on_phases,
  input  wire logic        ab_current_sense,
  input  wire logic        cd_current_sense,
  input  wire logic        sync_i,
  output logic             sync_o,
  output logic             sync_oe,
  input  wire logic        home_i,
  output logic             home_o,
  output logic             home_oe,
  output logic [3:0]       phase_abcd,
  output logic             ab_pair_inhibit_n,
  output logic             cd_pair_inhibit_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  stpc_core_t  c_q;
  stpc_core_t  c_d;
  stpc_chop_if chop ();

  logic        step_rise;
  logic [2:0]  step_incr;
  logic [3:0]  ph_raw;
  logic        pair_ab_on;
  logic        pair_cd_on;
  logic        bus_take;
  logic [5:0]  take_idx;
  logic [31:0] status_word;
  logic [3:0]  ph_now;

  stpc_chop_osc stpc_chop_osc_inst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .chop    (chop.osc),
    .sync_i  (sync_i),
    .sync_o  (sync_o),
    .sync_oe (sync_oe)
  );

  stpc_chop_latch stpc_chop_latch_inst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .chop    (chop.latch)
  );

  assign chop.period   = c_q.period;
  assign chop.ext_sync = c_q.ext_sync;
  assign chop.sense_ab = ab_current_sense;
  assign chop.sense_cd = cd_current_sense;

  // Index of a word register from a byte address
  function automatic logic [5:0] reg_index(input logic [31:0] addr);
    return addr[`STPC_ADDR_MSB:`STPC_ADDR_LSB];
  endfunction

  // Read value for a register index, using the freshest control values
  function automatic logic [31:0] read_word(input logic [5:0] idx,
                                            input stpc_core_t c,
                                            input logic [31:0] status);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == reg_index({24'h00_0000, `STPC_ADDR_CTRL})) begin
      w[`STPC_CTRL_EXT_SYNC] = c.ext_sync;
    end else if (idx == reg_index({24'h00_0000, `STPC_ADDR_PERIOD})) begin
      w[`STPC_PERIOD_W-1:0] = c.period;
    end else if (idx == reg_index({24'h00_0000, `STPC_ADDR_STATUS})) begin
      w = status;
    end
    return w;
  endfunction

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STPC_ST_POS_MSB:`STPC_ST_POS_LSB] = c_q.pos;
    status_word[`STPC_ST_PH_MSB:`STPC_ST_PH_LSB]   = c_q.phases;
    status_word[`STPC_ST_INH_AB]     = c_q.inh_ab_n;
    status_word[`STPC_ST_INH_CD]     = c_q.inh_cd_n;
    status_word[`STPC_ST_HOME]       = ~c_q.home_drive;
    status_word[`STPC_ST_LATCH_AB]   = chop.ab_chop_latch;
    status_word[`STPC_ST_LATCH_CD]   = chop.cd_chop_latch;
    status_word[`STPC_ST_HOME_PIN]   = home_i;
    status_word[`STPC_ST_HALF]       = half_step_sel;
    status_word[`STPC_ST_PHASE_CHOP] = chop_on_phases;
    status_word[`STPC_ST_ENABLE]     = chip_enable;
  end

  assign step_rise = step_clock & ~c_q.step_prev;
  assign step_incr = half_step_sel ? `STPC_HALF_INCR : `STPC_FULL_INCR;
  assign bus_take  = hsel & hready & htrans[`STPC_HTRANS_ACTIVE];
  assign take_idx  = reg_index(haddr);

  always_comb begin
    c_d = c_q;
    c_d.step_prev = step_clock;

    // Translator position
    if (!translator_reset_n) begin
      c_d.pos = `STPC_HOME_STATE;
    end else if (step_rise) begin
      // Direction is sampled only here, so it may move at any time
      if (rotation_direction) begin
        c_d.pos = c_q.pos + step_incr;
      end else begin
        c_d.pos = c_q.pos - step_incr;
      end
    end

    // Phase pattern and winding pair activity
    ph_raw     = stpc_phase_of(c_d.pos);
    pair_ab_on = ph_raw[3] | ph_raw[2];
    pair_cd_on = ph_raw[1] | ph_raw[0];
    c_d.phases   = ph_raw;
    c_d.inh_ab_n = pair_ab_on;
    c_d.inh_cd_n = pair_cd_on;

    // Chopper acts on phases or on inhibits
    if (chop_on_phases) begin
      if (pair_ab_on && !chop.ab_chop_latch) begin
        c_d.phases[3:2] = 2'b11;
      end
      if (pair_cd_on && !chop.cd_chop_latch) begin
        c_d.phases[1:0] = 2'b11;
      end
    end else begin
      c_d.inh_ab_n = pair_ab_on & chop.ab_chop_latch;
      c_d.inh_cd_n = pair_cd_on & chop.cd_chop_latch;
    end

    if (!chip_enable) begin
      c_d.phases   = 4'h0;
      c_d.inh_ab_n = 1'b0;
      c_d.inh_cd_n = 1'b0;
    end

    // Home flag releases the pin only in state 1
    c_d.home_drive = (c_d.pos != `STPC_HOME_STATE);

    // AHB-Lite data phase: apply a pending write
    if (c_q.bus == STPC_BUS_DATA && c_q.bus_wr) begin
      if (c_q.bus_idx == reg_index({24'h00_0000, `STPC_ADDR_CTRL})) begin
        c_d.ext_sync = hwdata[`STPC_CTRL_EXT_SYNC];
      end else if (c_q.bus_idx == reg_index({24'h00_0000, `STPC_ADDR_PERIOD})) begin
        if (hwdata[`STPC_PERIOD_W-1:0] < `STPC_PERIOD_MIN) begin
          c_d.period = `STPC_PERIOD_MIN;
        end else begin
          c_d.period = hwdata[`STPC_PERIOD_W-1:0];
        end
      end
    end

    // AHB-Lite address phase
    if (bus_take) begin
      c_d.bus     = STPC_BUS_DATA;
      c_d.bus_wr  = hwrite;
      c_d.bus_idx = take_idx;
      c_d.rdata   = hwrite ? 32'h0000_0000 : read_word(take_idx, c_d, status_word);
    end else if (hready) begin
      c_d.bus    = STPC_BUS_IDLE;
      c_d.bus_wr = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      c_q <= '{step_prev:  1'b1,
               pos:        `STPC_HOME_STATE,
               phases:     4'h0,
               inh_ab_n:   1'b0,
               inh_cd_n:   1'b0,
               home_drive: 1'b0,
               bus:        STPC_BUS_IDLE,
               bus_wr:     1'b0,
               bus_idx:    6'h00,
               rdata:      32'h0000_0000,
               ext_sync:   1'b0,
               period:     `STPC_PERIOD_RESET};
    end else begin
      c_q <= c_d;
    end
  end

  assign phase_abcd        = c_q.phases;
  assign ab_pair_inhibit_n = c_q.inh_ab_n;
  assign cd_pair_inhibit_n = c_q.inh_cd_n;
  assign home_o            = 1'b0;
  assign home_oe           = c_q.home_drive;
  assign hreadyout         = 1'b1;
  assign hresp             = `STPC_RESP_OKAY;
  assign hrdata            = c_q.rdata;

  assign ph_now = stpc_phase_of(c_q.pos);

  AST_STEP_ONLY_ON_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    translator_reset_n && !(step_clock && !c_q.step_prev) |=> $stable(c_q.pos))
    else $error("position moved without a step clock rising edge");

  AST_HOME_ON_RESET: assert property (@(posedge ref_clk) disable iff (reset)
    !translator_reset_n && chip_enable && (!chop_on_phases || (chop.ab_chop_latch
    && chop.cd_chop_latch)) |=> c_q.pos == `STPC_HOME_STATE
    && phase_abcd == `STPC_HOME_PHASES)
    else $error("translator reset did not restore state 1");

  AST_HOME_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (ph_now == `STPC_HOME_PHASES) == !home_oe)
    else $error("home flag disagrees with state 1");

  AST_ENABLE_LOW: assert property (@(posedge ref_clk) disable iff (reset)
    !chip_enable |=> phase_abcd == 4'h0 && !ab_pair_inhibit_n && !cd_pair_inhibit_n)
    else $error("outputs active while enable low");

  AST_HALF_STEP_MOVE: assert property (@(posedge ref_clk) disable iff (reset)
    translator_reset_n && step_clock && !c_q.step_prev && half_step_sel
    |=> c_q.pos == ($past(rotation_direction) ? $past(c_q.pos) + 3'h1
                                             : $past(c_q.pos) - 3'h1))
    else $error("half step did not move one position in the selected direction");

  AST_FULL_STEP_PARITY: assert property (@(posedge ref_clk) disable iff (reset)
    translator_reset_n && step_clock && !c_q.step_prev && !half_step_sel
    |=> c_q.pos[0] == $past(c_q.pos[0]) && c_q.pos != $past(c_q.pos))
    else $error("full step changed wave or normal drive type");

  AST_DEENERGISED_INHIBIT: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 ph_now[3:2] == 2'b00 |-> !ab_pair_inhibit_n)
    else $error("de-energised A/B pair not inhibited");

  AST_NORMAL_INHIBITS_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop_on_phases |=> c_q.pos[0] || (ab_pair_inhibit_n && cd_pair_inhibit_n))
    else $error("inhibit low during two-phase-on drive");

  AST_CHOP_ON_INHIBIT: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && !chop_on_phases && !chop.ab_chop_latch |=> !ab_pair_inhibit_n)
    else $error("inhibit chopping missing for A/B pair");

  AST_CHOP_ON_PHASES: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop_on_phases && !chop.cd_chop_latch
    |=> (ph_now[1:0] == 2'b00) || (phase_abcd[1:0] == 2'b11 && cd_pair_inhibit_n))
    else $error("phase chopping did not activate the inactive C/D line");

  AST_CD_DEENERGISED_INHIBIT: assert property (@(posedge ref_clk) disable iff (reset)
    ph_now[1:0] == 2'b00 |-> !cd_pair_inhibit_n)
    else $error("de-energised C/D pair not inhibited");

  AST_CW_STEP_SIZE: assert property (@(posedge ref_clk) disable iff (reset)
    translator_reset_n && step_clock && !c_q.step_prev && rotation_direction
    |=> c_q.pos - $past(c_q.pos) == ($past(half_step_sel) ? `STPC_HALF_INCR
                                                          : `STPC_FULL_INCR))
    else $error("clockwise step moved by the wrong amount");

  AST_ANTICLOCKWISE: assert property (@(posedge ref_clk) disable iff (reset)
    translator_reset_n && step_clock && !c_q.step_prev && !rotation_direction
    |=> $past(c_q.pos) - c_q.pos == ($past(half_step_sel) ? `STPC_HALF_INCR
                                                          : `STPC_FULL_INCR))
    else $error("anticlockwise step did not reverse the sequence");

  AST_PHASE_TABLE: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop.ab_chop_latch && chop.cd_chop_latch |=> phase_abcd == ph_now)
    else $error("unchopped phases differ from the state table");

  AST_WAVE_ONE_PHASE: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop.ab_chop_latch && chop.cd_chop_latch
    |=> !c_q.pos[0] || $countones(phase_abcd) == 1)
    else $error("even state does not drive exactly one phase");

  AST_NORMAL_TWO_PHASE: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop.ab_chop_latch && chop.cd_chop_latch
    |=> c_q.pos[0] || $countones(phase_abcd) == 2)
    else $error("odd state does not drive exactly two phases");

  AST_HOME_FLAG_PHASES: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop.ab_chop_latch && chop.cd_chop_latch
    |=> (phase_abcd == `STPC_HOME_PHASES) == !home_oe)
    else $error("home flag disagrees with phase outputs");

  AST_CHOP_ON_INHIBIT_CD: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && !chop_on_phases && !chop.cd_chop_latch |=> !cd_pair_inhibit_n)
    else $error("inhibit chopping missing for C/D pair");

  AST_CHOP_ON_PHASES_AB: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop_on_phases && !chop.ab_chop_latch
    |=> (ph_now[3:2] == 2'b00) || (phase_abcd[3:2] == 2'b11 && ab_pair_inhibit_n))
    else $error("phase chopping did not activate the inactive A/B line");

  AST_ACTIVE_LINE_KEPT: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable |=> (phase_abcd & ph_now) == ph_now)
    else $error("chopping interrupted an active phase line");

  AST_INHIBIT_MODE_PHASES: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && !chop_on_phases |=> phase_abcd == ph_now)
    else $error("phase lines chopped while inhibits selected");

  AST_PHASE_MODE_INHIBITS: assert property (@(posedge ref_clk) disable iff (reset)
    chip_enable && chop_on_phases |=> ab_pair_inhibit_n == (ph_now[3:2] != 2'b00)
    && cd_pair_inhibit_n == (ph_now[1:0] != 2'b00))
    else $error("inhibits chopped while phase lines selected");

  AST_READ_DATA_HELD: assert property (@(posedge ref_clk) disable iff (reset)
    !(hsel && hready && htrans[`STPC_HTRANS_ACTIVE]) |=> $stable(hrdata))
    else $error("read data changed without an address phase");

  AST_CTRL_WRITE_LANDS: assert property (@(posedge ref_clk) disable iff (reset)
    c_q.bus == STPC_BUS_DATA && c_q.bus_wr && c_q.bus_idx == reg_index({24'h00_0000,
    `STPC_ADDR_CTRL}) |=> c_q.ext_sync == $past(hwdata[`STPC_CTRL_EXT_SYNC]))
    else $error("sync source select write did not land");

endmodule // stpc_translator_top
`default_nettype wire

// [design/stpc_regs.svh]
// Register map, field positions, reset values and counts of the stepper translator
`ifndef STPC_REGS_SVH
`define STPC_REGS_SVH

`define STPC_ADDR_CTRL        8'h00
`define STPC_ADDR_PERIOD      8'h04
`define STPC_ADDR_STATUS      8'h08
`define STPC_ADDR_LSB         2
`define STPC_ADDR_MSB         7

`define STPC_CTRL_EXT_SYNC    0

`define STPC_ST_POS_LSB       0
`define STPC_ST_POS_MSB       2
`define STPC_ST_PH_LSB        3
`define STPC_ST_PH_MSB        6
`define STPC_ST_INH_AB        7
`define STPC_ST_INH_CD        8
`define STPC_ST_HOME          9
`define STPC_ST_LATCH_AB      10
`define STPC_ST_LATCH_CD      11
`define STPC_ST_HOME_PIN      12
`define STPC_ST_HALF          13
`define STPC_ST_PHASE_CHOP    14
`define STPC_ST_ENABLE        15

`define STPC_PERIOD_RESET     16'h0320
`define STPC_PERIOD_MIN       16'h0002
`define STPC_PERIOD_W         16

`define STPC_HOME_STATE       3'h0
`define STPC_HOME_PHASES      4'h5
`define STPC_HALF_INCR        3'h1
`define STPC_FULL_INCR        3'h2

`define STPC_HTRANS_ACTIVE    1
`define STPC_RESP_OKAY        1'b0

`endif

// [design/stpc_pkg.sv]
// Types and shared decode of the stepper translator
package stpc_pkg;

  typedef enum logic {
    STPC_BUS_IDLE = 1'b0,
    STPC_BUS_DATA = 1'b1
  } stpc_bus_t;

  typedef struct packed {
    logic [15:0] count;
    logic        sync_prev;
    logic        pulse;
  } stpc_osc_t;

  typedef struct packed {
    logic ab;
    logic cd;
  } stpc_latch_t;

  typedef struct packed {
    logic        step_prev;
    logic [2:0]  pos;
    logic [3:0]  phases;
    logic        inh_ab_n;
    logic        inh_cd_n;
    logic        home_drive;
    stpc_bus_t   bus;
    logic        bus_wr;
    logic [5:0]  bus_idx;
    logic [31:0] rdata;
    logic        ext_sync;
    logic [15:0] period;
  } stpc_core_t;

  // Phase pattern A,B,C,D (A is bit 3) for position index 0..7 (states 1..8)
  function automatic logic [3:0] stpc_phase_of(input logic [2:0] pos);
    logic [3:0] ph;
    case (pos)
      3'h0: ph = 4'h5;
      3'h1: ph = 4'h1;
      3'h2: ph = 4'h9;
      3'h3: ph = 4'h8;
      3'h4: ph = 4'ha;
      3'h5: ph = 4'h2;
      3'h6: ph = 4'h6;
      3'h7: ph = 4'h4;
      default: ph = 4'h5;
    endcase
    return ph;
  endfunction

endpackage

// [design/stpc_chop_if.sv]
// Chopper signals shared between the core, the oscillator and the chop latches
`timescale 1ns/100ps
`default_nettype none
interface stpc_chop_if;
  logic [15:0] period;
  logic        ext_sync;
  logic        osc_pulse;
  logic        sense_ab;
  logic        sense_cd;
  logic        ab_chop_latch;
  logic        cd_chop_latch;

  modport core  (output period, ext_sync, sense_ab, sense_cd,
                 input  osc_pulse, ab_chop_latch, cd_chop_latch);
  modport osc   (input  period, ext_sync, output osc_pulse);
  modport latch (input  osc_pulse, sense_ab, sense_cd,
                 output ab_chop_latch, cd_chop_latch);
endinterface
`default_nettype wire

// [design/stpc_chop_osc.sv]
// Chopper oscillator with sync line output and external clock injection
`timescale 1ns/100ps
`default_nettype none
`include "stpc_regs.svh"
module stpc_chop_osc
  import stpc_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  reset,
  stpc_chop_if.osc   chop,
  input  wire logic  sync_i,
  output logic       sync_o,
  output logic       sync_oe
);
  stpc_osc_t s_q;
  stpc_osc_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sync_prev = sync_i;
    s_d.pulse = 1'b0;
    if (chop.ext_sync) begin
      s_d.pulse = sync_i & ~s_q.sync_prev;
      s_d.count = chop.period - 16'h0001;
    end else if (s_q.count == 16'h0000) begin
      s_d.pulse = 1'b1;
      s_d.count = chop.period - 16'h0001;
    end else begin
      s_d.count = s_q.count - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '{count: `STPC_PERIOD_RESET, sync_prev: 1'b0, pulse: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign chop.osc_pulse = s_q.pulse;
  assign sync_o         = s_q.pulse;
  assign sync_oe        = ~chop.ext_sync;

  AST_SYNC_RELEASED: assert property (@(posedge ref_clk) disable iff (reset)
    chop.ext_sync |-> !sync_oe)
    else $error("sync line driven while external chopper clock selected");
  AST_PULSE_SINGLE: assert property (@(posedge ref_clk) disable iff (reset)
    chop.osc_pulse && $past(chop.period) >= `STPC_PERIOD_MIN |=> !chop.osc_pulse)
    else $error("chopper pulse longer than one cycle");
endmodule // stpc_chop_osc
`default_nettype wire

// [design/stpc_chop_latch.sv]
// Per-pair chop latches set by the oscillator and cleared by the current comparators
`timescale 1ns/100ps
`default_nettype none
module stpc_chop_latch
  import stpc_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  reset,
  stpc_chop_if.latch chop
);
  stpc_latch_t l_q;
  stpc_latch_t l_d;

  always_comb begin
    l_d = l_q;
    // Pulse wins so a new chop period is never lost
    if (chop.osc_pulse) begin
      l_d.ab = 1'b1;
      l_d.cd = 1'b1;
    end else begin
      if (chop.sense_ab) l_d.ab = 1'b0;
      if (chop.sense_cd) l_d.cd = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      l_q <= '{ab: 1'b1, cd: 1'b1};
    end else begin
      l_q <= l_d;
    end
  end

  assign chop.ab_chop_latch = l_q.ab;
  assign chop.cd_chop_latch = l_q.cd;

  AST_LATCH_SET: assert property (@(posedge ref_clk) disable iff (reset)
    chop.osc_pulse |=> chop.ab_chop_latch && chop.cd_chop_latch)
    else $error("chop latches not set by oscillator pulse");
  AST_LATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    !chop.osc_pulse && chop.sense_cd && !chop.sense_ab && chop.ab_chop_latch
    |=> !chop.cd_chop_latch && chop.ab_chop_latch)
    else $error("sense of one pair disturbed the other pair");
endmodule // stpc_chop_latch
`default_nettype wire

// [testbench/stpc_host_model.sv]
// Host controller model driving the step, direction, mode and translator reset lines
`timescale 1ns/100ps
`default_nettype none
module stpc_host_model (
  input  wire logic ref_clk,
  output logic      step_clock,
  output logic      rotation_direction,
  output logic      half_step_sel,
  output logic      translator_reset_n
);
  initial begin
    step_clock         = 1'b1;
    rotation_direction = 1'b1;
    half_step_sel      = 1'b1;
    translator_reset_n = 1'b1;
  end

  // One active-low pulse per step of one or two positions; direction is flipped while low, final at the rise
  task automatic do_step(input logic dir, input logic half, input int slow);
    @(posedge ref_clk);
    step_clock         <= 1'b0;
    rotation_direction <= ~dir;
    half_step_sel      <= half;
    repeat (1 + slow) @(posedge ref_clk);
    rotation_direction <= dir;
    repeat (1 + slow) @(posedge ref_clk);
    step_clock <= 1'b1;
    repeat (3 + slow) @(posedge ref_clk);
  endtask

  // Level of the translator reset line
  task automatic hold_reset(input logic v);
    @(posedge ref_clk);
    translator_reset_n <= v;
  endtask
endmodule // stpc_host_model
`default_nettype wire

// [testbench/stpc_translator_top_tb.sv]
// Self-checking bench for the stepper translator top
`timescale 1ns/100ps
`default_nettype none
`include "stpc_regs.svh"
`define CHK(got, exp, what) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: %s", $time, what); end end
module stpc_translator_top_tb;
  localparam logic [3:0] PH_TAB [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};
  logic        ref_clk;
  logic        reset;
  logic        chip_enable;
  logic        chop_on_phases;
  logic        ab_current_sense;
  logic        cd_current_sense;
  logic        tb_sync;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        step_clock;
  logic        rotation_direction;
  logic        half_step_sel;
  logic        translator_reset_n;
  logic        sync_o;
  logic        sync_oe;
  logic        home_o;
  logic        home_oe;
  logic [3:0]  phase_abcd;
  logic        ab_pair_inhibit_n;
  logic        cd_pair_inhibit_n;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  wire         sync_line;
  wire         home_line;
  int          n_errors;
  int          check_count;
  int          n;
  logic [2:0]  exp_idx;
  logic [31:0] rd;

  assign sync_line = sync_oe ? sync_o : tb_sync;
  assign home_line = home_oe ? home_o : 1'b1;

  stpc_host_model stpc_host_model_inst (
    .ref_clk            (ref_clk),
    .step_clock         (step_clock),
    .rotation_direction (rotation_direction),
    .half_step_sel      (half_step_sel),
    .translator_reset_n (translator_reset_n)
  );

  stpc_translator_top stpc_translator_top_inst (
    .ref_clk, .reset, .step_clock, .rotation_direction, .half_step_sel, .chip_enable,
    .translator_reset_n, .chop_on_phases, .ab_current_sense, .cd_current_sense,
    .sync_i (sync_line), .sync_o, .sync_oe, .home_i (home_line), .home_o, .home_oe,
    .phase_abcd, .ab_pair_inhibit_n, .cd_pair_inhibit_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready (hreadyout), .hreadyout, .hresp, .hrdata
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: bus hang", $time);
      print_verdict();
    end
  endtask

  // Single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic chk_state();
    logic [3:0] ph;
    ph = PH_TAB[exp_idx];
    `CHK(phase_abcd, ph, "phases")
    `CHK(ab_pair_inhibit_n, |ph[3:2], "ab inhibit")
    `CHK(cd_pair_inhibit_n, |ph[1:0], "cd inhibit")
    `CHK(home_line, exp_idx == 3'h0, "home flag")
    ahb(1'b0, `STPC_ADDR_STATUS, 32'h0);
    `CHK(rd[6:0], {ph, exp_idx}, "status position")
  endtask

  task automatic step_chk(input logic dir, input logic half, input int slow);
    logic [2:0] inc;
    inc = half ? 3'h1 : 3'h2;
    stpc_host_model_inst.do_step(dir, half, slow);
    exp_idx = dir ? exp_idx + inc : exp_idx - inc;
    chk_state();
  endtask

  task automatic sync_pulse();
    tb_sync <= 1'b1;
    repeat (2) @(posedge ref_clk);
    tb_sync <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    reset = 1'b1;
    chip_enable = 1'b1;
    chop_on_phases = 1'b0;
    ab_current_sense = 1'b0;
    cd_current_sense = 1'b0;
    tb_sync = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    n_errors = 0;
    check_count = 0;
    exp_idx = 3'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_state();
    ahb(1'b0, `STPC_ADDR_PERIOD, 32'h0);
    `CHK(rd[15:0], `STPC_PERIOD_RESET, "period reset")
    `CHK(hresp, `STPC_RESP_OKAY, "response")
    ahb(1'b1, 8'h0c, 32'hffffffff);
    ahb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    for (int i = 0; i < 8; i++) step_chk(1'b1, 1'b1, 0);
    for (int i = 0; i < 3; i++) step_chk(1'b0, 1'b1, 0);
    for (int i = 0; i < 2; i++) step_chk(1'b0, 1'b0, 0);
    step_chk(1'b1, 1'b1, 0);
    for (int i = 0; i < 4; i++) begin
      step_chk(1'b1, 1'b0, i);
      `CHK({ab_pair_inhibit_n, cd_pair_inhibit_n}, 2'b11, "normal inhibits")
    end
    stpc_host_model_inst.hold_reset(1'b0);
    stpc_host_model_inst.do_step(1'b1, 1'b1, 0);
    stpc_host_model_inst.hold_reset(1'b1);
    repeat (2) @(posedge ref_clk);
    exp_idx = 3'h0;
    chk_state();
    chip_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK({phase_abcd, ab_pair_inhibit_n, cd_pair_inhibit_n}, 6'h00, "enable low")
    chip_enable <= 1'b1;
    ahb(1'b1, `STPC_ADDR_PERIOD, 32'h1);
    ahb(1'b0, `STPC_ADDR_PERIOD, 32'h0);
    `CHK(rd[15:0], `STPC_PERIOD_MIN, "period floor")
    n = 0;
    while (sync_o !== 1'b1 && n < 900) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(sync_o, 1'b1, "first sync pulse")
    n = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (sync_o === 1'b1) n++;
    end
    `CHK((n >= 9) && (n <= 11) && (sync_oe === 1'b1), 1'b1, "sync rate")
    ahb(1'b1, `STPC_ADDR_CTRL, 32'h1);
    ahb(1'b0, `STPC_ADDR_CTRL, 32'h0);
    `CHK({rd[0], sync_oe}, 2'b10, "external sync")
    ab_current_sense <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK({ab_pair_inhibit_n, cd_pair_inhibit_n}, 2'b01, "ab chop")
    ab_current_sense <= 1'b0;
    sync_pulse();
    `CHK({ab_pair_inhibit_n, cd_pair_inhibit_n}, 2'b11, "sync sets latch")
    chop_on_phases <= 1'b1;
    cd_current_sense <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK({phase_abcd, ab_pair_inhibit_n, cd_pair_inhibit_n}, 6'h1f, "phase chop")
    cd_current_sense <= 1'b0;
    sync_pulse();
    `CHK(phase_abcd, 4'h5, "phase chop end")
    chop_on_phases <= 1'b0;
    print_verdict();
  end
endmodule // stpc_translator_top_tb
`default_nettype wire
